//--- rscc_regs.svh
// Purpose: register offsets, field codes and timing figures of the radio state control block
// Assumes: 250 MHz core clock, 8-bit register port
// Notes: cycle counts derive from the printed microsecond figures
`ifndef RSCC_REGS_SVH
`define RSCC_REGS_SVH
// register offsets
`define RSCC_OFF_STATUS 8'h01
`define RSCC_OFF_CMD 8'h02
`define RSCC_OFF_RETRY 8'h03
// field positions
`define RSCC_CODE_MSB 4
`define RSCC_TRAC_LSB 5
// reset values
`define RSCC_STATUS_RST 8'h00
`define RSCC_MAX_FRAME_RST 4'h3
`define RSCC_MAX_CSMA_RST 3'h4
// radio state codes
`define RSCC_ST_PON 5'h00
`define RSCC_ST_BUSY_RX 5'h01
`define RSCC_ST_BUSY_TX 5'h02
`define RSCC_ST_RX_ON 5'h06
`define RSCC_ST_IDLE 5'h08
`define RSCC_ST_PLL 5'h09
`define RSCC_ST_SLEEP 5'h0f
`define RSCC_ST_BUSY_AACK 5'h11
`define RSCC_ST_BUSY_ARET 5'h12
`define RSCC_ST_AACK_ON 5'h16
`define RSCC_ST_ARET_ON 5'h19
`define RSCC_ST_RX_NOCLK 5'h1c
`define RSCC_ST_AACK_NOCLK 5'h1d
`define RSCC_ST_BUSY_AACK_NOCLK 5'h1e
`define RSCC_ST_PENDING 5'h1f
// command codes
`define RSCC_CMD_NOP 5'h00
`define RSCC_CMD_TX_START 5'h02
`define RSCC_CMD_FORCE_IDLE 5'h03
`define RSCC_CMD_FORCE_PLL 5'h04
`define RSCC_CMD_RX_ON 5'h06
`define RSCC_CMD_IDLE 5'h08
`define RSCC_CMD_PLL 5'h09
`define RSCC_CMD_AACK 5'h16
`define RSCC_CMD_ARET 5'h19
// transaction result codes
`define RSCC_TRAC_SUCCESS 3'h0
`define RSCC_TRAC_PENDING 3'h1
`define RSCC_TRAC_CHAN_FAIL 3'h3
`define RSCC_TRAC_NO_ACK 3'h5
`define RSCC_TRAC_INVALID 3'h7
// timing figures in microseconds and clock rate
`define RSCC_CLK_MHZ 250
`define RSCC_T_FAST_US 1
`define RSCC_T_TX_US 16
`define RSCC_T_PLL_US 110
`define RSCC_T_WAKE_US 380
`define RSCC_T_BACKOFF_US 320
`define RSCC_T_ACKW_US 864
`define RSCC_FAST_CYC (`RSCC_T_FAST_US * `RSCC_CLK_MHZ)
`define RSCC_TX_CYC (`RSCC_T_TX_US * `RSCC_CLK_MHZ)
`endif

//--- rscc_pkg.sv
// Purpose: types shared by the radio state control block
// Assumes: nothing beyond the register header
// Notes: states are one-hot
package rscc_pkg;
  typedef enum logic [11:0] {
    RS_PON = 12'h001,
    RS_SLEEP = 12'h002,
    RS_IDLE = 12'h004,
    RS_PLL = 12'h008,
    RS_RX_ON = 12'h010,
    RS_BUSY_RX = 12'h020,
    RS_BUSY_TX = 12'h040,
    RS_AACK_ON = 12'h080,
    RS_BUSY_AACK = 12'h100,
    RS_ARET_ON = 12'h200,
    RS_BUSY_ARET = 12'h400,
    RS_PEND = 12'h800
  } rscc_state_t;

  typedef enum logic [3:0] {
    AP_BACKOFF = 4'h1,
    AP_CCA = 4'h2,
    AP_TX = 4'h4,
    AP_ACKW = 4'h8
  } rscc_phase_t;

  // register port request
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } rscc_bus_t;

  // receive path events
  typedef struct packed {
    logic frame_busy;
    logic frame_start;
    logic frame_end;
    logic fcs_ok;
    logic addr_match;
    logic ack_wanted;
    logic ack_done;
  } rscc_rx_ev_t;

  // transmit path, channel check and acknowledgement events
  typedef struct packed {
    logic tx_done;
    logic tx_ack_req;
    logic [7:0] tx_seq;
    logic channel_check_done;
    logic cca_busy;
    logic ack_rx;
    logic ack_fcs_ok;
    logic ack_pending;
    logic [7:0] ack_seq;
  } rscc_tx_ev_t;
endpackage

//--- rscc_timer.sv
// Purpose: down counter timing transitions, back-off and ack wait
// Assumes: load wins over counting
// Notes: done is a one-cycle pulse, registered
`timescale 1ns/1ps
`default_nettype none
module rscc_timer #(
  parameter int TW = 18
) (
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic load_in,
  input wire logic [TW-1:0] val_in,
  output logic done_out
);
  logic [TW-1:0] cnt_reg;
  logic done_reg;

  // count down to zero, flag the step from one to zero
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      cnt_reg <= '0;
      done_reg <= 1'b0;
    end else if (load_in) begin
      cnt_reg <= val_in;
      done_reg <= 1'b0;
    end else begin
      done_reg <= (cnt_reg == TW'(1));
      if (cnt_reg != '0) begin
        cnt_reg <= cnt_reg - TW'(1);
      end
    end
  end

  assign done_out = done_reg;
endmodule
`default_nettype wire

//--- rscc_ctrl.sv
// Purpose: radio state control, command decode and status report
// Assumes: register port inputs and radio events synchronous to clk_in
// Notes: a commanded or pin-driven transition shows the pending code until its timer expires; frame events switch at once
// What this block and its host model do
// RQ1 - status read returns state code bits 4:0
// RQ2 - command field write starts state transition
// RQ3 - pin rising edge starts transition where applicable
// RQ4 - basic state codes as listed
// RQ5 - extended state codes as listed
// RQ6 - pending code shown until transition finishes
// RQ7 - host avoids commands while pending shown
// RQ8 - status not accessible during sleep
// RQ9 - command field decodes listed values
// RQ10 - undefined commands act as no operation
// RQ11 - forced synth-on ignored in clockless states
// RQ12 - auto modes entered only from idle/synth
// RQ13 - host confirms each state by reading
// RQ14 - auto-ack entry shows listen or receiving
// RQ15 - idle/synth held back until procedure ends
// RQ16 - forced commands abort auto transactions at once
// RQ17 - auto-ack checks every frame check sequence
// RQ18 - ack sent only for filtered valid requests
// RQ19 - receive and address-match interrupts gated
// RQ20 - ack accepted: in time, valid, matching
// RQ21 - result follows ack frame-pending bit
// RQ22 - retransmit missing acks after channel back-off
// RQ23 - reserved bit zero, status writes ignored
`timescale 1ns/1ps
`default_nettype none
`include "rscc_regs.svh"
module rscc_ctrl
  import rscc_pkg::*;
#(
  parameter int TW = 18,
  parameter int PLL_CYC = `RSCC_T_PLL_US * `RSCC_CLK_MHZ,
  parameter int WAKE_CYC = `RSCC_T_WAKE_US * `RSCC_CLK_MHZ,
  parameter int BACKOFF_CYC = `RSCC_T_BACKOFF_US * `RSCC_CLK_MHZ,
  parameter int ACKW_CYC = `RSCC_T_ACKW_US * `RSCC_CLK_MHZ
) (
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire rscc_bus_t bus_in,
  input wire logic sleep_transmit_pin_in,
  input wire rscc_rx_ev_t rx_in,
  input wire rscc_tx_ev_t tx_in,
  output logic [7:0] rd_data_out,
  output logic [4:0] radio_state_field_out,
  output logic tx_go_out,
  output logic cca_req_out,
  output logic ack_send_out,
  output logic rx_end_irq_out,
  output logic addr_match_irq_out
);
  localparam logic [TW-1:0] C_FAST = TW'(`RSCC_FAST_CYC);
  localparam logic [TW-1:0] C_TX = TW'(`RSCC_TX_CYC);
  localparam logic [TW-1:0] C_PLL = TW'(PLL_CYC);
  localparam logic [TW-1:0] C_WAKE = TW'(WAKE_CYC);
  localparam logic [TW-1:0] C_BACKOFF = TW'(BACKOFF_CYC);
  localparam logic [TW-1:0] C_ACKW = TW'(ACKW_CYC);

  typedef struct packed {
    rscc_state_t state;
    rscc_state_t target;
    rscc_state_t defer_tgt;
    logic defer_vld;
    rscc_phase_t phase;
    logic [3:0] frame_cnt;
    logic [2:0] csma_cnt;
    logic [3:0] max_frame;
    logic [2:0] max_csma;
    logic [2:0] trac;
    logic channel_check_done;
    logic cca_clear;
    logic pin;
    logic [7:0] rd_data;
    logic [4:0] code;
    logic tx_go;
    logic cca_req;
    logic ack_send;
    logic rx_end;
    logic amatch;
  } rscc_ctx_t;

  rscc_ctx_t s_reg;
  rscc_ctx_t s_next;
  logic tmr_load;
  logic [TW-1:0] tmr_val;
  logic tmr_done;

  rscc_timer #(.TW(TW)) u_timer (
    .clk_in(clk_in),
    .resetn_in(resetn_in),
    .load_in(tmr_load),
    .val_in(tmr_val),
    .done_out(tmr_done)
  );

  // state to reported code
  function automatic logic [4:0] code_of(input rscc_state_t st);
    case (st)
      RS_PON: code_of = `RSCC_ST_PON; // [RQ4]
      RS_SLEEP: code_of = `RSCC_ST_SLEEP;
      RS_IDLE: code_of = `RSCC_ST_IDLE;
      RS_PLL: code_of = `RSCC_ST_PLL;
      RS_RX_ON: code_of = `RSCC_ST_RX_ON;
      RS_BUSY_RX: code_of = `RSCC_ST_BUSY_RX;
      RS_BUSY_TX: code_of = `RSCC_ST_BUSY_TX;
      RS_AACK_ON: code_of = `RSCC_ST_AACK_ON; // [RQ5]
      RS_BUSY_AACK: code_of = `RSCC_ST_BUSY_AACK;
      RS_ARET_ON: code_of = `RSCC_ST_ARET_ON;
      RS_BUSY_ARET: code_of = `RSCC_ST_BUSY_ARET;
      default: code_of = `RSCC_ST_PENDING; // [RQ6]
    endcase
  endfunction

  logic cmd_wr;
  logic [4:0] cmd;
  logic pin_rise;
  logic go;
  rscc_state_t go_tgt;
  logic [TW-1:0] go_cyc;
  logic finish;
  logic ack_ok;
  logic busy_st;
  logic idle_pend;

  // next state of the whole block
  always_comb begin
    s_next = s_reg;
    s_next.tx_go = 1'b0;
    s_next.cca_req = 1'b0;
    s_next.ack_send = 1'b0;
    s_next.rx_end = 1'b0;
    s_next.amatch = 1'b0;
    s_next.pin = sleep_transmit_pin_in;
    go = 1'b0;
    go_tgt = RS_IDLE;
    go_cyc = C_FAST;
    finish = 1'b0;
    tmr_load = 1'b0;
    tmr_val = C_FAST;
    pin_rise = sleep_transmit_pin_in & ~s_reg.pin;
    cmd_wr = bus_in.wr && (bus_in.addr == `RSCC_OFF_CMD) && (s_reg.state != RS_SLEEP);
    cmd = bus_in.wdata[`RSCC_CODE_MSB:0];
    ack_ok = tx_in.ack_rx && tx_in.ack_fcs_ok && (tx_in.ack_seq == tx_in.tx_seq); // [RQ20]
    busy_st = (s_reg.state == RS_BUSY_RX) || (s_reg.state == RS_BUSY_TX) ||
              (s_reg.state == RS_BUSY_AACK) || (s_reg.state == RS_BUSY_ARET);
    idle_pend = (s_reg.state == RS_PEND) && ((s_reg.target == RS_IDLE) ||
                (s_reg.target == RS_SLEEP) || (s_reg.target == RS_PON));

    // register writes other than commands; status writes fall through
    if (bus_in.wr && (bus_in.addr == `RSCC_OFF_RETRY) && (s_reg.state != RS_SLEEP)) begin
      s_next.max_frame = bus_in.wdata[7:4];
      s_next.max_csma = bus_in.wdata[3:1];
    end

    // register reads, answered one cycle later
    if (bus_in.rd) begin
      if (s_reg.state == RS_SLEEP) begin
        s_next.rd_data = 8'h00; // [RQ8]
      end else if (bus_in.addr == `RSCC_OFF_STATUS) begin
        s_next.rd_data = {s_reg.channel_check_done, s_reg.cca_clear, 1'b0, code_of(s_reg.state)}; // [RQ1] [RQ23]
      end else if (bus_in.addr == `RSCC_OFF_CMD) begin
        s_next.rd_data = {s_reg.trac, 5'h00};
      end else if (bus_in.addr == `RSCC_OFF_RETRY) begin
        s_next.rd_data = {s_reg.max_frame, s_reg.max_csma, 1'b0};
      end else begin
        s_next.rd_data = 8'h00;
      end
    end

    // state machine: events of the current state
    case (s_reg.state)
      RS_PEND: begin
        if (tmr_done) begin
          s_next.state = s_reg.target;
          if (s_reg.target == RS_BUSY_TX) begin
            s_next.tx_go = 1'b1;
          end else if (s_reg.target == RS_BUSY_ARET) begin
            s_next.phase = AP_BACKOFF;
            s_next.frame_cnt = 4'h0;
            s_next.csma_cnt = 3'h0;
            s_next.trac = `RSCC_TRAC_INVALID;
            tmr_load = 1'b1;
            tmr_val = C_BACKOFF; // [RQ22]
          end else if ((s_reg.target == RS_AACK_ON) && rx_in.frame_busy) begin
            s_next.state = RS_BUSY_AACK; // [RQ14]
          end
        end
      end
      RS_SLEEP: begin
        if (!sleep_transmit_pin_in) begin
          go = 1'b1;
          go_cyc = C_WAKE;
        end
      end
      RS_IDLE: begin
        if (pin_rise) begin
          go = 1'b1; // [RQ3]
          go_tgt = RS_SLEEP;
        end
      end
      RS_PLL: begin
        if (pin_rise) begin
          go = 1'b1; // [RQ3]
          go_tgt = RS_BUSY_TX;
          go_cyc = C_TX;
        end
      end
      RS_ARET_ON: begin
        if (pin_rise) begin
          go = 1'b1; // [RQ3]
          go_tgt = RS_BUSY_ARET;
        end
      end
      RS_RX_ON: begin
        if (rx_in.frame_start) begin
          s_next.state = RS_BUSY_RX;
        end
      end
      RS_BUSY_RX: begin
        if (rx_in.frame_end) begin
          s_next.rx_end = 1'b1;
          finish = 1'b1;
        end
      end
      RS_BUSY_TX: begin
        if (tx_in.tx_done) begin
          finish = 1'b1;
        end
      end
      RS_AACK_ON: begin
        if (rx_in.frame_start) begin
          s_next.state = RS_BUSY_AACK;
        end
      end
      RS_BUSY_AACK: begin
        if (rx_in.frame_end) begin
          // frame check judged on every frame
          s_next.amatch = rx_in.addr_match; // [RQ19]
          s_next.rx_end = rx_in.fcs_ok && rx_in.addr_match; // [RQ17] [RQ19]
          if (rx_in.fcs_ok && rx_in.addr_match && rx_in.ack_wanted) begin
            s_next.ack_send = 1'b1; // [RQ18]
          end else begin
            finish = 1'b1;
          end
        end else if (rx_in.ack_done) begin
          finish = 1'b1;
        end
      end
      RS_BUSY_ARET: begin
        case (s_reg.phase)
          AP_BACKOFF: begin
            if (tmr_done) begin
              s_next.cca_req = 1'b1; // [RQ22]
              s_next.channel_check_done = 1'b0;
              s_next.phase = AP_CCA;
            end
          end
          AP_CCA: begin
            if (tx_in.channel_check_done) begin
              s_next.channel_check_done = 1'b1;
              s_next.cca_clear = ~tx_in.cca_busy;
              if (!tx_in.cca_busy) begin
                s_next.tx_go = 1'b1;
                s_next.csma_cnt = 3'h0;
                s_next.phase = AP_TX;
              end else if (s_reg.csma_cnt == s_reg.max_csma) begin
                s_next.trac = `RSCC_TRAC_CHAN_FAIL;
                finish = 1'b1;
              end else begin
                s_next.csma_cnt = s_reg.csma_cnt + 3'h1; // [RQ22]
                s_next.phase = AP_BACKOFF;
                tmr_load = 1'b1;
                tmr_val = C_BACKOFF;
              end
            end
          end
          AP_TX: begin
            if (tx_in.tx_done) begin
              if (tx_in.tx_ack_req) begin
                s_next.phase = AP_ACKW;
                tmr_load = 1'b1;
                tmr_val = C_ACKW; // [RQ20]
              end else begin
                s_next.trac = `RSCC_TRAC_SUCCESS;
                finish = 1'b1;
              end
            end
          end
          default: begin
            if (ack_ok) begin
              s_next.trac = tx_in.ack_pending ? `RSCC_TRAC_PENDING : `RSCC_TRAC_SUCCESS; // [RQ21]
              finish = 1'b1;
            end else if (tmr_done) begin
              if (s_reg.frame_cnt == s_reg.max_frame) begin
                s_next.trac = `RSCC_TRAC_NO_ACK;
                finish = 1'b1;
              end else begin
                s_next.frame_cnt = s_reg.frame_cnt + 4'h1; // [RQ22]
                s_next.phase = AP_BACKOFF;
                tmr_load = 1'b1;
                tmr_val = C_BACKOFF;
              end
            end
          end
        endcase
      end
      default: begin
      end
    endcase

    // end of a busy procedure: deferred command or home state
    if (finish) begin
      if (s_reg.defer_vld) begin
        go = 1'b1; // [RQ15]
        go_tgt = s_reg.defer_tgt;
        s_next.defer_vld = 1'b0;
      end else if (s_reg.state == RS_BUSY_RX) begin
        s_next.state = RS_RX_ON;
      end else if (s_reg.state == RS_BUSY_TX) begin
        s_next.state = RS_PLL;
      end else if (s_reg.state == RS_BUSY_AACK) begin
        s_next.state = RS_AACK_ON;
      end else begin
        s_next.state = RS_ARET_ON;
      end
    end

    // command decode, pending blocks all but forced idle, and forced synth unless pending toward idle, sleep or power-on
    if (cmd_wr) begin
      if (cmd == `RSCC_CMD_FORCE_IDLE) begin
        go = (s_reg.state != RS_PON); // [RQ16]
        go_tgt = RS_IDLE;
        go_cyc = C_FAST;
        s_next.defer_vld = 1'b0;
      end else if (cmd == `RSCC_CMD_FORCE_PLL) begin
        if ((s_reg.state != RS_PON) && (s_reg.state != RS_IDLE) && !idle_pend) begin
          go = 1'b1; // [RQ11] [RQ16]
          go_tgt = RS_PLL;
          go_cyc = C_FAST;
          s_next.defer_vld = 1'b0;
        end
      end else if (s_reg.state != RS_PEND) begin
        if ((cmd == `RSCC_CMD_IDLE) || (cmd == `RSCC_CMD_PLL)) begin // [RQ9]
          go_tgt = (cmd == `RSCC_CMD_IDLE) ? RS_IDLE : RS_PLL;
          if (busy_st) begin
            s_next.defer_vld = 1'b1; // [RQ15]
            s_next.defer_tgt = go_tgt;
          end else if (s_reg.state != go_tgt) begin
            go = 1'b1; // [RQ2]
            go_cyc = ((s_reg.state == RS_IDLE) || (s_reg.state == RS_PON)) ? C_PLL : C_FAST;
          end
        end else if (cmd == `RSCC_CMD_RX_ON) begin
          if ((s_reg.state == RS_IDLE) || (s_reg.state == RS_PLL)) begin
            go = 1'b1; // [RQ2]
            go_tgt = RS_RX_ON;
            go_cyc = (s_reg.state == RS_IDLE) ? C_PLL : C_FAST;
          end
        end else if ((cmd == `RSCC_CMD_AACK) || (cmd == `RSCC_CMD_ARET)) begin
          if ((s_reg.state == RS_IDLE) || (s_reg.state == RS_PLL)) begin
            go = 1'b1; // [RQ12]
            go_tgt = (cmd == `RSCC_CMD_AACK) ? RS_AACK_ON : RS_ARET_ON;
            go_cyc = (s_reg.state == RS_IDLE) ? C_PLL : C_FAST;
          end
        end else if (cmd == `RSCC_CMD_TX_START) begin
          if (s_reg.state == RS_PLL) begin
            go = 1'b1; // [RQ2]
            go_tgt = RS_BUSY_TX;
            go_cyc = C_TX;
          end else if (s_reg.state == RS_ARET_ON) begin
            go = 1'b1;
            go_tgt = RS_BUSY_ARET;
            go_cyc = C_FAST;
          end
        end
        // other codes leave the state alone [RQ10]
      end
    end

    // start a timed transition, reported as pending
    if (go) begin
      s_next.state = RS_PEND; // [RQ6]
      s_next.target = go_tgt;
      tmr_load = 1'b1;
      tmr_val = go_cyc;
    end
    s_next.code = code_of(s_next.state);
  end

  // state register
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      s_reg.state <= RS_PON;
      s_reg.target <= RS_IDLE;
      s_reg.defer_tgt <= RS_IDLE;
      s_reg.defer_vld <= 1'b0;
      s_reg.phase <= AP_BACKOFF;
      s_reg.frame_cnt <= 4'h0;
      s_reg.csma_cnt <= 3'h0;
      s_reg.max_frame <= `RSCC_MAX_FRAME_RST;
      s_reg.max_csma <= `RSCC_MAX_CSMA_RST;
      s_reg.trac <= `RSCC_TRAC_SUCCESS;
      s_reg.channel_check_done <= 1'b0;
      s_reg.cca_clear <= 1'b0;
      s_reg.pin <= 1'b0;
      s_reg.rd_data <= `RSCC_STATUS_RST;
      s_reg.code <= `RSCC_ST_PON;
      s_reg.tx_go <= 1'b0;
      s_reg.cca_req <= 1'b0;
      s_reg.ack_send <= 1'b0;
      s_reg.rx_end <= 1'b0;
      s_reg.amatch <= 1'b0;
    end else begin
      s_reg <= s_next;
    end
  end

  // outputs straight from the state register
  assign rd_data_out = s_reg.rd_data;
  assign radio_state_field_out = s_reg.code;
  assign tx_go_out = s_reg.tx_go;
  assign cca_req_out = s_reg.cca_req;
  assign ack_send_out = s_reg.ack_send;
  assign rx_end_irq_out = s_reg.rx_end;
  assign addr_match_irq_out = s_reg.amatch;
endmodule
`default_nettype wire

//--- rscc_host.sv
// Purpose: host model on the register port of the radio state control block
// Assumes: one-cycle strobes, read data in the cycle after the read strobe
// Notes: commands sent through cmd wait out the pending code and are confirmed by reading; wr sends a command at once
`timescale 1ns/1ps
`default_nettype none
module rscc_host
  import rscc_pkg::*;
(
  input wire logic clk_in,
  input wire logic [7:0] rd_data_in,
  output var rscc_bus_t bus_out
);
  initial bus_out = '0;
  // one-cycle write strobe
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_in) bus_out <= '{a, d, 1'b1, 1'b0};
    @(posedge clk_in) bus_out.wr <= 1'b0;
  endtask
  // read strobe, data taken at the end of the following cycle
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_in) bus_out <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge clk_in) bus_out.rd <= 1'b0;
    @(posedge clk_in) d = rd_data_in;
  endtask
  // bounded status polling
  task automatic poll(input logic [4:0] e, input int n, output logic [7:0] s);
    for (int i = 0; i < n; i++) begin
      rd(8'h01, s);
      if (s[4:0] == e) break;
    end
  endtask
  // command only after the pending code clears, then confirm the state
  task automatic cmd(input logic [4:0] c, input logic [4:0] e, input int n, output logic [7:0] s);
    s = 8'h1f;
    for (int i = 0; i < n && s[4:0] == 5'h1f; i++) rd(8'h01, s);
    wr(8'h02, {3'h0, c});
    poll(e, n, s);
  endtask
endmodule
`default_nettype wire

//--- rscc_ctrl_props.sv
// Purpose: port checks of the radio state control block
// Assumes: fast moves reach their target 251 cycles after the first pending cycle
// Notes: bound to every rscc_ctrl instance
`timescale 1ns/1ps
`default_nettype none
module rscc_ctrl_props
  import rscc_pkg::*;
(
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire rscc_bus_t bus_in,
  input wire logic sleep_transmit_pin_in,
  input wire rscc_rx_ev_t rx_in,
  input wire rscc_tx_ev_t tx_in,
  input wire logic [7:0] rd_data_out,
  input wire logic [4:0] radio_state_field_out,
  input wire logic tx_go_out,
  input wire logic cca_req_out,
  input wire logic ack_send_out,
  input wire logic rx_end_irq_out,
  input wire logic addr_match_irq_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!resetn_in);
  // shorthands for state, command write and frame end
  wire logic [4:0] f = radio_state_field_out;
  wire logic wc = bus_in.wr && bus_in.addr == 8'h02;
  wire logic [4:0] c = bus_in.wdata[4:0];
  wire logic fe = rx_in.frame_end && f == 5'h11;
  property p_rd; bus_in.rd && bus_in.addr == 8'h01 && f != 5'h0f |=> rd_data_out[5:0] == {1'b0, $past(f)}; endproperty
  a_rd: assert property (p_rd) else $error("status read");
  property p_pend; wc && c == 5'h09 && f == 5'h08 |=> f == 5'h1f [*8]; endproperty
  a_pend: assert property (p_pend) else $error("pending code");
  property p_undef;
    wc && !(c inside {5'h02, 5'h03, 5'h04, 5'h06, 5'h08, 5'h09, 5'h16, 5'h19}) && f == 5'h08
      && !$rose(sleep_transmit_pin_in) |=> f == 5'h08;
  endproperty
  a_undef: assert property (p_undef) else $error("undefined command acted");
  property p_fpll; wc && c == 5'h04 && f inside {5'h00, 5'h08} && !$rose(sleep_transmit_pin_in) |=> $stable(f); endproperty
  a_fpll: assert property (p_fpll) else $error("forced synth acted");
  property p_auto; wc && c inside {5'h16, 5'h19} && f == 5'h06 |=> f != 5'h1f; endproperty
  a_auto: assert property (p_auto) else $error("auto mode from listen");
  property p_force; wc && c == 5'h03 && f inside {5'h11, 5'h12, 5'h16, 5'h19} |=> f == 5'h1f ##251 f == 5'h08; endproperty
  a_force: assert property (p_force) else $error("forced idle");
  property p_pin; $rose(sleep_transmit_pin_in) && f == 5'h08 && !bus_in.wr |=> f == 5'h1f ##251 f == 5'h0f; endproperty
  a_pin: assert property (p_pin) else $error("pin to sleep");
  property p_irq;
    fe |=> rx_end_irq_out == $past(rx_in.fcs_ok && rx_in.addr_match) && addr_match_irq_out == $past(rx_in.addr_match);
  endproperty
  a_irq: assert property (p_irq) else $error("frame interrupts");
  property p_ack; fe |=> ack_send_out == $past(rx_in.fcs_ok && rx_in.addr_match && rx_in.ack_wanted); endproperty
  a_ack: assert property (p_ack) else $error("ack send");
  property p_slp; bus_in.rd && f == 5'h0f |=> rd_data_out == 8'h00; endproperty
  a_slp: assert property (p_slp) else $error("read in sleep");
  // main scenarios reached
  c_ack: cover property (ack_send_out);
  c_cca: cover property (cca_req_out && !tx_go_out);
  c_tx: cover property (tx_go_out && tx_in.tx_seq == 8'h05);
endmodule
bind rscc_ctrl rscc_ctrl_props u_props (.clk_in(clk_in), .resetn_in(resetn_in), .bus_in(bus_in),
  .sleep_transmit_pin_in(sleep_transmit_pin_in), .rx_in(rx_in), .tx_in(tx_in), .rd_data_out(rd_data_out),
  .radio_state_field_out(radio_state_field_out), .tx_go_out(tx_go_out), .cca_req_out(cca_req_out),
  .ack_send_out(ack_send_out), .rx_end_irq_out(rx_end_irq_out), .addr_match_irq_out(addr_match_irq_out));
`default_nettype wire

//--- radio_state_command_control_tb_top.sv
// Purpose: self-checking bench of the radio state control block
// Assumes: shortened synth, wake, back-off and ack-wait counts, host model on the register port
// Notes: radio events are one-cycle pulses driven here
`timescale 1ns/1ps
`default_nettype none
module radio_state_command_control_tb_top
  import rscc_pkg::*;
;
  localparam rscc_tx_ev_t TX0 = '{tx_seq: 8'h05, default: '0};
  logic clk_in = 1'b0;
  logic resetn_in = 1'b0;
  logic pin = 1'b0;
  rscc_rx_ev_t rx = '0;
  rscc_tx_ev_t tx = TX0;
  wire rscc_bus_t bus;
  wire logic [7:0] rdat;
  wire logic [4:0] po;
  int cnt [5] = '{default: 0};
  int mismatches = 0;
  int cmp_count = 0;
  logic [7:0] s;
  always #2 clk_in = ~clk_in;
  rscc_ctrl #(.PLL_CYC(20), .WAKE_CYC(30), .BACKOFF_CYC(8), .ACKW_CYC(40)) u_dut (.clk_in(clk_in),
    .resetn_in(resetn_in), .bus_in(bus), .sleep_transmit_pin_in(pin), .rx_in(rx), .tx_in(tx),
    .rd_data_out(rdat), .radio_state_field_out(), .tx_go_out(po[0]), .cca_req_out(po[1]),
    .ack_send_out(po[2]), .rx_end_irq_out(po[3]), .addr_match_irq_out(po[4]));
  rscc_host u_host (.clk_in(clk_in), .rd_data_in(rdat), .bus_out(bus));
  // count each output pulse
  always @(posedge clk_in) for (int i = 0; i < 5; i++) cnt[i] += int'(po[i] === 1'b1);
  task automatic chk(input string n, input logic [7:0] g, input logic [7:0] e);
    cmp_count++;
    if (g !== e) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic report_and_stop;
    $display("mismatches %0d comparisons %0d", mismatches, cmp_count);
    if (mismatches == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // check a polled state, stop if lost
  task automatic ck(input logic [4:0] e);
    chk("state", {3'h0, s[4:0]}, {3'h0, e});
    if (s[4:0] !== e) report_and_stop();
  endtask
  // command then confirm
  task automatic go(input logic [4:0] c, input logic [4:0] e, input int n);
    u_host.cmd(c, e, n, s);
    ck(e);
  endtask
  // bounded wait for a pulse count
  task automatic wt(input int i, input int n);
    for (int k = 0; k < 600 && cnt[i] < n; k++) @(posedge clk_in);
    chk("pulses", 8'(cnt[i]), 8'(n));
    if (cnt[i] < n) report_and_stop();
  endtask
  task automatic rxp(input rscc_rx_ev_t v);
    @(posedge clk_in) rx <= v;
    @(posedge clk_in) rx <= '0;
  endtask
  task automatic txp(input rscc_tx_ev_t v);
    @(posedge clk_in) tx <= v;
    @(posedge clk_in) tx <= TX0;
  endtask
  task automatic t_regs;
    u_host.rd(8'h01, s);
    chk("status", s, 8'h00);
    u_host.wr(8'h01, 8'hff);
    u_host.rd(8'h01, s);
    chk("status", s, 8'h00);
    u_host.rd(8'h40, s);
    chk("unmapped", s, 8'h00);
  endtask
  task automatic t_cmds;
    logic [4:0] c [13] = '{5'h05, 5'h04, 5'h09, 5'h06, 5'h16, 5'h09, 5'h16, 5'h19, 5'h04, 5'h19, 5'h03, 5'h1b, 5'h00};
    logic [4:0] e [13] = '{5'h08, 5'h08, 5'h09, 5'h06, 5'h06, 5'h09, 5'h16, 5'h16, 5'h09, 5'h19, 5'h08, 5'h08, 5'h08};
    u_host.wr(8'h02, 8'h08);
    u_host.rd(8'h01, s);
    chk("pending", s, 8'h1f);
    u_host.poll(5'h08, 100, s);
    ck(5'h08);
    for (int i = 0; i < 13; i++) go(c[i], e[i], 200);
  endtask
  task automatic t_pin;
    @(posedge clk_in) pin <= 1'b1;
    repeat (260) @(posedge clk_in);
    u_host.rd(8'h01, s);
    chk("sleep read", s, 8'h00);
    u_host.wr(8'h02, 8'h09);
    @(posedge clk_in) pin <= 1'b0;
    u_host.poll(5'h08, 100, s);
    ck(5'h08);
    go(5'h09, 5'h09, 100);
    go(5'h02, 5'h02, 1500);
    wt(0, 1);
    txp('{tx_seq: 8'h05, tx_done: 1'b1, default: '0});
    u_host.poll(5'h09, 100, s);
    ck(5'h09);
  endtask
  task automatic t_aack;
    go(5'h16, 5'h16, 100);
    rxp(7'b0100000);
    u_host.poll(5'h11, 5, s);
    ck(5'h11);
    rxp(7'b0011110);
    u_host.wr(8'h02, 8'h09);
    u_host.rd(8'h01, s);
    chk("held", {3'h0, s[4:0]}, 8'h11);
    chk("ack", 8'(cnt[2]), 8'h01);
    chk("rx end", 8'(cnt[3]), 8'h01);
    rxp(7'b0000001);
    u_host.poll(5'h09, 100, s);
    ck(5'h09);
    go(5'h16, 5'h16, 100);
    rxp(7'b0100000);
    rxp(7'b0010110);
    repeat (4) @(posedge clk_in);
    chk("ack", 8'(cnt[2]), 8'h01);
    chk("rx end", 8'(cnt[3]), 8'h01);
    chk("addr", 8'(cnt[4]), 8'h02);
  endtask
  task automatic t_aret;
    go(5'h09, 5'h09, 100);
    go(5'h19, 5'h19, 100);
    @(posedge clk_in) pin <= 1'b1;
    wt(1, 1);
    txp('{tx_seq: 8'h05, channel_check_done: 1'b1, default: '0});
    wt(0, 2);
    txp('{tx_seq: 8'h05, tx_done: 1'b1, tx_ack_req: 1'b1, default: '0});
    wt(1, 2);
    txp('{tx_seq: 8'h05, channel_check_done: 1'b1, default: '0});
    wt(0, 3);
    txp('{tx_seq: 8'h05, tx_done: 1'b1, tx_ack_req: 1'b1, default: '0});
    txp('{tx_seq: 8'h05, ack_rx: 1'b1, ack_fcs_ok: 1'b1, ack_seq: 8'h06, default: '0});
    txp('{tx_seq: 8'h05, ack_rx: 1'b1, ack_fcs_ok: 1'b1, ack_pending: 1'b1, ack_seq: 8'h05, default: '0});
    u_host.poll(5'h19, 20, s);
    ck(5'h19);
    u_host.rd(8'h02, s);
    chk("result", {5'h00, s[7:5]}, 8'h01);
    @(posedge clk_in) pin <= 1'b0;
    go(5'h03, 5'h08, 100);
  endtask
  // reset, scenarios, verdict
  initial begin
    repeat (3) @(posedge clk_in);
    resetn_in <= 1'b1;
    t_regs();
    t_cmds();
    t_pin();
    t_aack();
    t_aret();
    report_and_stop();
  end
endmodule
`default_nettype wire
